// ### rtl/ddf_frame_decoder.sv
// serial frame decoder and register file of a dual-channel dac
// Operation
// (RL1) frames are exactly 24 bits, held whole
// (RL2) bits shift in most significant first
// (RL3) flag, zero, register, channel, 16 data bits
// (RL4) host drives reserved bit to zero
// (RL5) top bit chooses read or write
// (RL6) register codes: dac, range, power, control
// (RL7) channel codes: a, b, both
// (RL8) every addressed register is read/write
// (RL9) twos complement maps around zero volts
// (RL10) straight binary maps zero to zero volts
// (RL11) offset binary maps midcode to zero volts
// (RL12) dac code sits in data bits 15:4
// (RL13) range bits pick one of six ranges
// (RL14) short or long frames are discarded
`include "ddf_consts.svh"
module ddf_frame_decoder (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // serial link pins
  input wire logic serialClock,
  input wire logic serial_data_input,
  input wire logic frameSyncN,
  // coding select pin, high for offset binary in bipolar ranges
  input wire logic offsetBinarySel,
  // frame event outputs
  output logic frameTaken_r,
  output logic frameDropped_r,
  output logic isRead_r,
  output ddf_pkg::ddf_regsel_t regSel_r,
  output ddf_pkg::ddf_chan_t chanSel_r,
  // readback word
  output logic [15:0] readData_r,
  // register contents
  output ddf_pkg::ddf_code_t dacCodeA_r,
  output ddf_pkg::ddf_code_t dacCodeB_r,
  output ddf_pkg::ddf_range_t rangeA_r,
  output ddf_pkg::ddf_range_t rangeB_r,
  output logic [15:0] powerCtl_r,
  output logic [15:0] control_r,
  // offset-binary level per channel, 000 is the lowest output
  output ddf_pkg::ddf_code_t levelA_r,
  output ddf_pkg::ddf_code_t levelB_r
);
  // ****************************************
  // pin synchronisation
  // ****************************************
  // synchronised copies of the pins
  logic [3:0] pinS;
  logic sclkS;
  logic sdinS;
  logic syncNS;
  logic binS;
  // previous synced clock and frame sync, for edge finding
  logic sclkD_r;
  logic syncND_r;

  // all four pins cross into the clock domain together
  ddf_sync #(.WIDTH(4), .INIT(4'h5)) uSync (
    .clock(clock),
    .rst(rst),
    .asyncIn({offsetBinarySel, frameSyncN, serial_data_input, serialClock}),
    .syncOut(pinS)
  );
  assign sclkS = pinS[0];
  assign sdinS = pinS[1];
  assign syncNS = pinS[2];
  assign binS = pinS[3];

  // delayed copies for edge detection
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sclkD_r <= 1'b1;
      syncND_r <= 1'b1;
    end else begin
      sclkD_r <= sclkS;
      syncND_r <= syncNS;
    end
  end

  // ****************************************
  // shift register and bit counter
  // ****************************************
  // falling serial clock inside a frame takes one bit
  logic sampleBit;
  logic frameStart;
  logic frameEnd;
  logic take;
  logic [23:0] shift_r;
  logic [4:0] bitCnt_r;
  assign sampleBit = sclkD_r & ~sclkS & ~syncNS;
  assign frameStart = syncND_r & ~syncNS;
  assign frameEnd = ~syncND_r & syncNS;
  // (RL14) only a full-length frame is acted on
  assign take = frameEnd && (bitCnt_r == `DDF_FRAME_BITS);

  // (RL2) shift left so the first bit ends on top
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      shift_r <= 24'h000000;
    end else if (sampleBit) begin
      shift_r <= {shift_r[22:0], sdinS};
    end
  end

  // (RL1) count bits, saturating past the frame length
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      bitCnt_r <= 5'h00;
    end else if (frameStart) begin
      bitCnt_r <= 5'h00;
    end else if (sampleBit && bitCnt_r != `DDF_CNT_SAT) begin
      bitCnt_r <= bitCnt_r + 5'h01;
    end
  end

  // ****************************************
  // field decode
  // ****************************************
  // fields of the held frame; the reserved zero bit is not checked
  logic frameRead;
  ddf_pkg::ddf_regsel_t frameReg;
  ddf_pkg::ddf_chan_t frameChan;
  logic hitA;
  logic hitB;
  logic doWrite;
  // (RL3) fixed field positions
  assign frameRead = shift_r[`DDF_RW_BIT];
  assign frameReg = shift_r[`DDF_REG_HI:`DDF_REG_LO];
  assign frameChan = shift_r[`DDF_CHAN_HI:`DDF_CHAN_LO];
  // (RL7) channel decode, other codes reach no channel
  assign hitA = (frameChan == `DDF_CHAN_A) || (frameChan == `DDF_CHAN_BOTH);
  assign hitB = (frameChan == `DDF_CHAN_B) || (frameChan == `DDF_CHAN_BOTH);
  // (RL5) low flag writes, high flag reads
  assign doWrite = take && !frameRead;

  // frame event outputs, one-cycle pulses and held fields
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      frameTaken_r <= 1'b0;
      frameDropped_r <= 1'b0;
      isRead_r <= 1'b0;
      regSel_r <= `DDF_REG_DAC;
      chanSel_r <= `DDF_CHAN_A;
    end else begin
      frameTaken_r <= take;
      // (RL14) report frames of wrong length
      frameDropped_r <= frameEnd && !take;
      if (take) begin
        isRead_r <= frameRead;
        regSel_r <= frameReg;
        chanSel_r <= frameChan;
      end
    end
  end

  // ****************************************
  // register writes
  // ****************************************
  // (RL6) register select steers each write
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      dacCodeA_r <= `DDF_RST_CODE;
      dacCodeB_r <= `DDF_RST_CODE;
      rangeA_r <= `DDF_RST_RANGE;
      rangeB_r <= `DDF_RST_RANGE;
      powerCtl_r <= `DDF_RST_WORD;
      control_r <= `DDF_RST_WORD;
    end else if (doWrite) begin
      case (frameReg)
        `DDF_REG_DAC: begin
          // (RL12) low four data bits dropped
          if (hitA) dacCodeA_r <= shift_r[`DDF_DATA_HI:`DDF_CODE_LO];
          if (hitB) dacCodeB_r <= shift_r[`DDF_DATA_HI:`DDF_CODE_LO];
        end
        `DDF_REG_RANGE: begin
          // (RL13) three range bits kept per channel
          if (hitA) rangeA_r <= shift_r[`DDF_RANGE_HI:0];
          if (hitB) rangeB_r <= shift_r[`DDF_RANGE_HI:0];
        end
        `DDF_REG_POWER: begin
          powerCtl_r <= shift_r[`DDF_DATA_HI:0];
        end
        `DDF_REG_CTRL: begin
          control_r <= shift_r[`DDF_DATA_HI:0];
        end
        default: begin
          // unknown register select, write ignored
        end
      endcase
    end
  end

  // ****************************************
  // readback
  // ****************************************
  // (RL8) reads return what was written; channel b only when a is not hit
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      readData_r <= `DDF_RST_WORD;
    end else if (take && frameRead) begin
      case (frameReg)
        `DDF_REG_DAC: readData_r <= {hitA ? dacCodeA_r : dacCodeB_r, 4'h0};
        `DDF_REG_RANGE: readData_r <= {13'h0000, hitA ? rangeA_r : rangeB_r};
        `DDF_REG_POWER: readData_r <= powerCtl_r;
        `DDF_REG_CTRL: readData_r <= control_r;
        default: readData_r <= `DDF_RST_WORD;
      endcase
    end
  end

  // ****************************************
  // code to level mapping
  // ****************************************
  // bipolar ranges are the codes 011 to 101
  function automatic logic is_bipolar(input ddf_pkg::ddf_range_t r);
    is_bipolar = (r >= `DDF_RANGE_BIP_MIN) && (r <= `DDF_RANGE_BIP_MAX);
  endfunction

  // level is offset binary: twos complement flips the top bit
  function automatic ddf_pkg::ddf_code_t to_level(input ddf_pkg::ddf_code_t c, input ddf_pkg::ddf_range_t r,
                                                  input logic offBin);
    // (RL9) twos complement: 000 is zero volts, 800 most negative
    if (is_bipolar(r) && !offBin) to_level = {~c[11], c[10:0]};
    // (RL10) (RL11) straight and offset binary pass through
    else to_level = c;
  endfunction

  // levels follow the stored codes one cycle later
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      levelA_r <= `DDF_RST_CODE;
      levelB_r <= `DDF_RST_CODE;
    end else begin
      levelA_r <= to_level(dacCodeA_r, rangeA_r, binS);
      levelB_r <= to_level(dacCodeB_r, rangeB_r, binS);
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  sequence s_dac_write;
    doWrite && frameReg == `DDF_REG_DAC;
  endsequence
  sequence s_range_write;
    doWrite && frameReg == `DDF_REG_RANGE;
  endsequence

  property p_full_frame;
    @(posedge clock) disable iff (rst) frameEnd && bitCnt_r == `DDF_FRAME_BITS |=> frameTaken_r && !frameDropped_r;
  endproperty
  a_full_frame: assert property (p_full_frame) else $error("full frame not taken"); // (RL1)

  property p_short_drop;
    @(posedge clock) disable iff (rst) frameEnd && bitCnt_r != `DDF_FRAME_BITS |=> frameDropped_r && !frameTaken_r;
  endproperty
  a_short_drop: assert property (p_short_drop) else $error("wrong length frame not dropped"); // (RL14)

  property p_msb_first;
    @(posedge clock) disable iff (rst) sampleBit |=> shift_r[0] == $past(sdinS) && shift_r[23:1] == $past(shift_r[22:0]);
  endproperty
  a_msb_first: assert property (p_msb_first) else $error("bit not shifted in at bottom"); // (RL2)

  property p_dac_a;
    @(posedge clock) disable iff (rst) s_dac_write ##0 hitA |=> dacCodeA_r == $past(shift_r[`DDF_DATA_HI:`DDF_CODE_LO]);
  endproperty
  a_dac_a: assert property (p_dac_a) else $error("channel a code not written"); // (RL12)

  property p_dac_both;
    @(posedge clock) disable iff (rst) s_dac_write ##0 frameChan == `DDF_CHAN_BOTH |=> dacCodeA_r == dacCodeB_r;
  endproperty
  a_dac_both: assert property (p_dac_both) else $error("both-channel write differs"); // (RL7)

  property p_range_b;
    @(posedge clock) disable iff (rst) s_range_write ##0 frameChan == `DDF_CHAN_B |=>
      rangeB_r == $past(shift_r[`DDF_RANGE_HI:0]) && $stable(rangeA_r);
  endproperty
  a_range_b: assert property (p_range_b) else $error("channel b range write wrong"); // (RL13)

  property p_read_ctrl;
    @(posedge clock) disable iff (rst) take && frameRead && frameReg == `DDF_REG_CTRL |=>
      readData_r == $past(control_r) && $stable(control_r);
  endproperty
  a_read_ctrl: assert property (p_read_ctrl) else $error("control readback wrong"); // (RL8)

  property p_twos_level;
    @(posedge clock) disable iff (rst) is_bipolar(rangeA_r) && !binS |=> levelA_r == {~$past(dacCodeA_r[11]),
      $past(dacCodeA_r[10:0])};
  endproperty
  a_twos_level: assert property (p_twos_level) else $error("twos complement level wrong"); // (RL9)

  property p_uni_level;
    @(posedge clock) disable iff (rst) !is_bipolar(rangeA_r) |=> levelA_r == $past(dacCodeA_r);
  endproperty
  a_uni_level: assert property (p_uni_level) else $error("straight binary level wrong"); // (RL10)
endmodule

// ### rtl/ddf_consts.svh
// named constants for the dual dac serial frame decoder
`ifndef DDF_CONSTS_SVH
`define DDF_CONSTS_SVH
// ****************************************
// frame geometry
// ****************************************
`define DDF_FRAME_BITS 5'h18
`define DDF_CNT_SAT 5'h19
`define DDF_RW_BIT 23
`define DDF_ZERO_BIT 22
`define DDF_REG_HI 21
`define DDF_REG_LO 19
`define DDF_CHAN_HI 18
`define DDF_CHAN_LO 16
`define DDF_DATA_HI 15
`define DDF_CODE_LO 4
`define DDF_RANGE_HI 2
// ****************************************
// register select and channel codes
// ****************************************
`define DDF_REG_DAC 3'h0
`define DDF_REG_RANGE 3'h1
`define DDF_REG_POWER 3'h2
`define DDF_REG_CTRL 3'h3
`define DDF_CHAN_A 3'h0
`define DDF_CHAN_B 3'h2
`define DDF_CHAN_BOTH 3'h4
// ****************************************
// range codes and reset values
// ****************************************
`define DDF_RANGE_BIP_MIN 3'h3
`define DDF_RANGE_BIP_MAX 3'h5
`define DDF_RST_CODE 12'h000
`define DDF_RST_RANGE 3'h0
`define DDF_RST_WORD 16'h0000
`endif

// ### rtl/ddf_pkg.sv
// shared types for the dual dac serial frame decoder
package ddf_pkg;
  // register select field value
  typedef logic [2:0] ddf_regsel_t;
  // channel address field value
  typedef logic [2:0] ddf_chan_t;
  // 12-bit dac code
  typedef logic [11:0] ddf_code_t;
  // output range code bits
  typedef logic [2:0] ddf_range_t;
endpackage

// ### rtl/ddf_sync.sv
// two flip-flop synchroniser for pin inputs
module ddf_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // asynchronous levels in, synchronised levels out
  input wire logic [WIDTH-1:0] asyncIn,
  output logic [WIDTH-1:0] syncOut
);
  // first stage, read only by the second stage
  logic [WIDTH-1:0] meta_r;

  // two stages in series
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      meta_r <= INIT;
      syncOut <= INIT;
    end else begin
      meta_r <= asyncIn;
      syncOut <= meta_r;
    end
  end
endmodule

// ### dv/ddf_host_model.sv
// host serial port model that shifts command frames into the decoder
module ddf_host_model (
  // serial link outputs
  output logic serialClock,
  output logic serialData,
  output logic frameSyncN
);
  timeunit 1ns;
  timeprecision 100ps;
  // link clock stands still high outside frames
  initial begin
    serialClock = 1'b1;
    serialData = 1'b0;
    frameSyncN = 1'b1;
  end
  // ****************************************
  // frame sender
  // ****************************************
  // nBits other than 24 makes a short or long frame on purpose
  task automatic send(input logic [23:0] word, input int nBits);
    frameSyncN = 1'b0;
    for (int i = 23; i > 23 - nBits; i--) begin
      serialData = (i < 0 || i == 22) ? 1'b0 : word[i];
      #62.5 serialClock = 1'b0;
      #62.5 serialClock = 1'b1;
    end
    #62.5 frameSyncN = 1'b1;
    // released line must not show the last bit
    serialData = ~serialData;
    #250;
  endtask
endmodule

// ### dv/dual_dac_serial_frame_decoder_tb.sv
// self-checking bench for the serial frame decoder
module dual_dac_serial_frame_decoder_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic offsetBinarySel = 1'b0;
  wire logic sck, sdi, fsN;
  logic frameTaken_r, frameDropped_r, isRead_r;
  ddf_pkg::ddf_regsel_t regSel_r;
  ddf_pkg::ddf_chan_t chanSel_r;
  logic [15:0] readData_r, powerCtl_r, control_r, pw, ct, rd;
  ddf_pkg::ddf_code_t dacCodeA_r, dacCodeB_r, levelA_r, levelB_r, cA, cB;
  ddf_pkg::ddf_range_t rangeA_r, rangeB_r, rA, rB;
  int err_total = 0;
  int num_checks = 0;
  int cycles = 0;
  int takenCnt = 0;
  int dropCnt = 0;
  int seed = 32'h8692;
  // boundary codes: positive max, zero, one below zero, most negative
  ddf_pkg::ddf_code_t edgeCodes [4] = '{12'h7ff, 12'h000, 12'hfff, 12'h800};
  always #4 clock = ~clock;
  ddf_host_model u_host (.serialClock(sck), .serialData(sdi), .frameSyncN(fsN));
  ddf_frame_decoder u_dut (.clock(clock), .rst(rst), .serialClock(sck), .serial_data_input(sdi),
    .frameSyncN(fsN), .offsetBinarySel(offsetBinarySel), .frameTaken_r(frameTaken_r),
    .frameDropped_r(frameDropped_r), .isRead_r(isRead_r), .regSel_r(regSel_r), .chanSel_r(chanSel_r),
    .readData_r(readData_r), .dacCodeA_r(dacCodeA_r), .dacCodeB_r(dacCodeB_r), .rangeA_r(rangeA_r),
    .rangeB_r(rangeB_r), .powerCtl_r(powerCtl_r), .control_r(control_r), .levelA_r(levelA_r),
    .levelB_r(levelB_r));
  // ****************************************
  // pulse counters and hang guard
  // ****************************************
  // pulses last one cycle, so count them where they stand
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (frameTaken_r === 1'b1) takenCnt <= takenCnt + 1;
    if (frameDropped_r === 1'b1) dropCnt <= dropCnt + 1;
    if (cycles == 60000) begin
      err_total++;
      finish_test();
    end
  end
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, got, exp);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d, mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // offset-binary level: msb flips for twos complement in bipolar ranges
  function automatic ddf_pkg::ddf_code_t lvl(input ddf_pkg::ddf_code_t c, input ddf_pkg::ddf_range_t r);
    return (r >= 3'h3 && r <= 3'h5 && !offsetBinarySel) ? c ^ 12'h800 : c;
  endfunction
  // ****************************************
  // frame with expected effect
  // ****************************************
  task automatic frame(input logic [23:0] w, input int nBits);
    int t0, d0;
    logic hA, hB;
    t0 = takenCnt;
    d0 = dropCnt;
    hA = w[18:16] == 3'h0 || w[18:16] == 3'h4;
    hB = w[18:16] == 3'h2 || w[18:16] == 3'h4;
    u_host.send(w, nBits);
    check(16'(takenCnt - t0), (nBits == 24) ? 16'h1 : 16'h0);
    check(16'(dropCnt - d0), (nBits == 24) ? 16'h0 : 16'h1);
    if (nBits == 24) begin
      check({12'h0, isRead_r, regSel_r}, {12'h0, w[23], w[21:19]});
      check({13'h0, chanSel_r}, {13'h0, w[18:16]});
      if (w[23]) begin
        case (w[21:19])
          3'h0: rd = {hA ? cA : cB, 4'h0};
          3'h1: rd = {13'h0, hA ? rA : rB};
          3'h2: rd = pw;
          3'h3: rd = ct;
          default: rd = 16'h0;
        endcase
      end else begin
        // power and control writes land whatever the channel code
        case (w[21:19])
          3'h0: begin
            if (hA) cA = w[15:4];
            if (hB) cB = w[15:4];
          end
          3'h1: begin
            if (hA) rA = w[2:0];
            if (hB) rB = w[2:0];
          end
          3'h2: pw = w[15:0];
          3'h3: ct = w[15:0];
          default: ;
        endcase
      end
    end
    check(readData_r, rd);
    check({dacCodeA_r, 4'h0}, {cA, 4'h0});
    check({dacCodeB_r, 4'h0}, {cB, 4'h0});
    check({10'h0, rangeA_r, rangeB_r}, {10'h0, rA, rB});
    check(powerCtl_r, pw);
    check(control_r, ct);
    check({4'h0, levelA_r}, {4'h0, lvl(cA, rA)});
    check({4'h0, levelB_r}, {4'h0, lvl(cB, rB)});
  endtask
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    logic [15:0] d;
    logic [2:0] c;
    {cA, cB, rA, rB, pw, ct, rd} = '0;
    repeat (10) @(posedge clock);
    #1 rst = 1'b0;
    repeat (4) @(posedge clock);
    check({levelA_r, rangeA_r, 1'b0}, 16'h0);
    check(readData_r | powerCtl_r | control_r, 16'h0);
    // write then read every register on channel codes a, b and both
    for (int r = 0; r < 4; r++) begin
      for (int k = 0; k < 3; k++) begin
        d = 16'($random(seed));
        frame({2'b00, 3'(r), 3'(2 * k), d}, 24);
        frame({2'b10, 3'(r), 3'(2 * k), d}, 24);
      end
    end
    // boundary codes in unipolar and bipolar ranges
    for (int g = 0; g < 2; g++) begin
      frame({5'h01, 3'h4, 13'h0, g ? 3'h3 : 3'h0}, 24);
      foreach (edgeCodes[k]) begin
        @(posedge clock) #1 offsetBinarySel = k[0];
        frame({5'h00, 3'h4, edgeCodes[k], 4'hf}, 24);
      end
    end
    // short and long frames are dropped
    frame(24'h00f123, 23);
    frame(24'h00f123, 25);
    // random mix with refused codes among it
    repeat (30) begin
      @(posedge clock) #1 offsetBinarySel = 1'($random(seed));
      c = ($random(seed) & 3) == 0 ? 3'($random(seed)) : {($random(seed) & 1) == 1, 2'b00};
      frame({1'($random(seed)), 1'b0, 3'($random(seed)), c, 16'($random(seed))}, 24);
    end
    finish_test();
  end
endmodule
